// ---- hw/cfg_id_csr.v ----
// Configuration identity word and command/status word with enables and error flags
`timescale 1ns/1ps
// What this block does
// R01 - Identity word: 16-bit vendor and device codes, read-only, fixed.
// R02 - Detected parity flag sets on master data or target address/data parity error.
// R03 - System error flag sets when target drives system error; needs enable bit.
// R04 - Received master abort flag sets when own master transaction master-aborts.
// R05 - Received target abort flag sets when target aborts own master transaction.
// R06 - Signalled target abort flag sets when own target ends with target-abort.
// R07 - Select timing field reads medium speed encoding constantly.
// R08 - With parity response on, master parity flag sets on master-side parity error report.
// R09 - Fast back-to-back capability and enable read zero; never used.
// R10 - Address parity reported on system error only if both enables set; reset zero.
// R11 - Parity response bit gates data parity error report; parity generation unaffected.
// R12 - Wait, palette snoop, write-invalidate and special-cycle bits read zero.
// R13 - Bus master enable loads address line 14 at power-on; gates slave images.
// R14 - Clearing master enable drains posted FIFO but blocks new FIFO data.
// R15 - Memory and I/O target enables load one when lines 13:12 are 10.
// R16 - Addresses with parity errors refused only when both enables are one.
// R17 - Error flags clear by writing one; writing zero keeps them; reset zero.
// R18 - Reserved bits read zero; software writes zero there.
// R19 - Register bytes are ordered little-endian.
// R20 - Config reads at both offsets, writes only at the command/status offset; byte enables select written bytes.
`include "cfg_id_csr_regs.vh"
module cfg_id_csr (
	mclk,
	rst_n,
	pwr_rst_n,
	vme_addr_strap,
	cfg_req,
	cfg_write,
	cfg_offset,
	cfg_byte_en,
	cfg_wdata,
	cfg_rdata,
	cfg_ack,
	mst_data_parity_err,
	tgt_addr_parity_err,
	tgt_data_parity_err,
	mst_perr_driven,
	tgt_perr_seen,
	mst_master_abort,
	mst_target_abort,
	tgt_target_abort,
	serr_drive,
	perr_drive_allow,
	addr_parity_refuse,
	bus_master_enable,
	target_memory_enable,
	target_io_enable,
	vme_slave_accept,
	fifo_accept_enable,
	fast_back_to_back_allow
);
	input wire mclk;
	input wire rst_n;
	input wire pwr_rst_n;
	input wire [2:0] vme_addr_strap;
	input wire cfg_req;
	input wire cfg_write;
	input wire [11:0] cfg_offset;
	input wire [3:0] cfg_byte_en;
	input wire [31:0] cfg_wdata;
	output reg [31:0] cfg_rdata;
	output reg cfg_ack;
	input wire mst_data_parity_err;
	input wire tgt_addr_parity_err;
	input wire tgt_data_parity_err;
	input wire mst_perr_driven;
	input wire tgt_perr_seen;
	input wire mst_master_abort;
	input wire mst_target_abort;
	input wire tgt_target_abort;
	output wire serr_drive;
	output wire perr_drive_allow;
	output wire addr_parity_refuse;
	output wire bus_master_enable;
	output wire target_memory_enable;
	output wire target_io_enable;
	output wire vme_slave_accept;
	output wire fifo_accept_enable;
	output wire fast_back_to_back_allow;

	// ----------------------------------------
	// Strap synchroniser
	// ----------------------------------------
	reg [2:0] strap_meta_q;
	reg [2:0] strap_sync_q;
	reg strap_load_q;

	always @(posedge mclk) begin
		strap_meta_q <= vme_addr_strap;
		strap_sync_q <= strap_meta_q;
	end

	// Latch strap on the first cycle after power-on or general reset release
	// A write to the master or target enables taken in that cycle is overridden by the strap load
	always @(posedge mclk) begin
		if (!rst_n || !pwr_rst_n) begin
			strap_load_q <= 1'b1;
		end else begin
			strap_load_q <= 1'b0;
		end
	end

	// Target enables come up only for the one strap pattern
	function tgt_strap_match;
		input [1:0] strap;
		begin
			tgt_strap_match = (strap == `TGT_STRAP_PATTERN);
		end
	endfunction

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	function is_csr;
		input [11:0] off;
		begin
			is_csr = (off == `OFF_CMD_STATUS);
		end
	endfunction

	wire wr_csr;
	wire [3:0] wr_lane;
	wire [31:0] wmask;
	wire [31:0] w1c;

	assign wr_csr = cfg_req && cfg_write && is_csr(cfg_offset);
	assign wr_lane = wr_csr ? cfg_byte_en : 4'h0; // R20

	// Little-endian lanes: byte enable k covers bits 8k+7..8k
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : lane
			assign wmask[8*g+7:8*g] = {8{wr_lane[g]}}; // R19
		end
	endgenerate

	// Clears act only where a one lands on an enabled lane
	assign w1c = cfg_wdata & wmask; // R17

	// ----------------------------------------
	// Writable command bits
	// ----------------------------------------
	reg parity_response_enable_q;
	reg system_error_enable_q;
	reg bus_master_enable_q;
	reg target_memory_enable_q;
	reg target_io_enable_q;

	always @(posedge mclk) begin
		if (!rst_n || !pwr_rst_n) begin
			parity_response_enable_q <= 1'b0; // R10
			system_error_enable_q <= 1'b0; // R10
		end else begin
			if (wmask[`B_PARITY_RESPONSE_ENABLE]) begin
				parity_response_enable_q <= cfg_wdata[`B_PARITY_RESPONSE_ENABLE];
			end
			if (wmask[`B_SYSTEM_ERROR_ENABLE]) begin
				system_error_enable_q <= cfg_wdata[`B_SYSTEM_ERROR_ENABLE];
			end
		end
	end

	always @(posedge mclk) begin
		if (!rst_n || !pwr_rst_n) begin
			bus_master_enable_q <= 1'b0;
			target_memory_enable_q <= 1'b0;
			target_io_enable_q <= 1'b0;
		end else if (strap_load_q) begin
			bus_master_enable_q <= strap_sync_q[2]; // R13
			target_memory_enable_q <= tgt_strap_match(strap_sync_q[1:0]); // R15
			target_io_enable_q <= tgt_strap_match(strap_sync_q[1:0]); // R15
		end else begin
			if (wmask[`B_BM]) begin
				bus_master_enable_q <= cfg_wdata[`B_BM];
			end
			if (wmask[`B_MS]) begin
				target_memory_enable_q <= cfg_wdata[`B_MS]; // R15
			end
			if (wmask[`B_IOS]) begin
				target_io_enable_q <= cfg_wdata[`B_IOS]; // R15
			end
		end
	end

	// ----------------------------------------
	// Error reporting gates
	// ----------------------------------------
	// System error needs both enables; parity response alone only allows PERR_
	wire both_en;
	assign both_en = parity_response_enable_q && system_error_enable_q;
	assign serr_drive = tgt_addr_parity_err && both_en; // R03 R10
	assign addr_parity_refuse = tgt_addr_parity_err && both_en; // R16
	assign perr_drive_allow = parity_response_enable_q; // R11
	assign fast_back_to_back_allow = 1'b0; // R09

	// ----------------------------------------
	// Enables presented to the bridge
	// ----------------------------------------
	assign bus_master_enable = bus_master_enable_q;
	assign target_memory_enable = target_memory_enable_q;
	assign target_io_enable = target_io_enable_q;
	assign vme_slave_accept = bus_master_enable_q; // R13
	// Posted FIFO keeps draining; only new entries are blocked
	assign fifo_accept_enable = bus_master_enable_q; // R14

	// ----------------------------------------
	// Sticky error flags
	// ----------------------------------------
	wire [5:0] flag_set;
	wire [5:0] flag_clr;
	wire [5:0] flag_q;

	assign flag_set[0] = mst_data_parity_err || tgt_addr_parity_err
		|| tgt_data_parity_err; // R02
	assign flag_set[1] = serr_drive; // R03
	assign flag_set[2] = mst_master_abort; // R04
	assign flag_set[3] = mst_target_abort; // R05
	assign flag_set[4] = tgt_target_abort; // R06
	assign flag_set[5] = parity_response_enable_q
		&& (mst_perr_driven || tgt_perr_seen); // R08

	assign flag_clr[0] = w1c[`B_DPE]; // R17
	assign flag_clr[1] = w1c[`B_SSERR];
	assign flag_clr[2] = w1c[`B_RMA];
	assign flag_clr[3] = w1c[`B_RTA];
	assign flag_clr[4] = w1c[`B_STA];
	assign flag_clr[5] = w1c[`B_DPD];

	// Either reset clears every flag
	generate
		for (g = 0; g < 6; g = g + 1) begin : flags
			w1c_flag u_flag (
				.mclk(mclk),
				.rst_n(rst_n && pwr_rst_n),
				.set_pulse(flag_set[g]),
				.clr_pulse(flag_clr[g]),
				.flag_q(flag_q[g])
			);
		end
	endgenerate

	wire detected_parity_error_flag;
	wire signalled_system_error_flag;
	wire received_master_abort_flag;
	wire received_target_abort_flag;
	wire signalled_target_abort_flag;
	wire master_data_parity_flag;

	assign detected_parity_error_flag = flag_q[0];
	assign signalled_system_error_flag = flag_q[1];
	assign received_master_abort_flag = flag_q[2];
	assign received_target_abort_flag = flag_q[3];
	assign signalled_target_abort_flag = flag_q[4];
	assign master_data_parity_flag = flag_q[5];

	// ----------------------------------------
	// Identity word and fixed fields
	// ----------------------------------------
	wire [31:0] identity_word;
	wire [1:0] select_timing_field;

	assign identity_word = {`DEVICE_ID_RST, `VENDOR_ID_RST}; // R01
	assign select_timing_field = `SEL_TIMING_MEDIUM; // R07

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	reg [31:0] csr_word;
	always @* begin
		csr_word = 32'h00000000; // R18 R12 R09
		csr_word[`B_IOS] = target_io_enable_q;
		csr_word[`B_MS] = target_memory_enable_q;
		csr_word[`B_BM] = bus_master_enable_q;
		csr_word[`B_PARITY_RESPONSE_ENABLE] = parity_response_enable_q;
		csr_word[`B_SYSTEM_ERROR_ENABLE] = system_error_enable_q;
		csr_word[`B_SEL_HI:`B_SEL_LO] = select_timing_field; // R07
		csr_word[`B_DPE] = detected_parity_error_flag;
		csr_word[`B_SSERR] = signalled_system_error_flag;
		csr_word[`B_RMA] = received_master_abort_flag;
		csr_word[`B_RTA] = received_target_abort_flag;
		csr_word[`B_STA] = signalled_target_abort_flag;
		csr_word[`B_DPD] = master_data_parity_flag;
	end

	// Read data holds until the next read
	always @(posedge mclk) begin
		if (!rst_n || !pwr_rst_n) begin
			cfg_rdata <= 32'h00000000;
			cfg_ack <= 1'b0;
		end else begin
			cfg_ack <= cfg_req;
			if (cfg_req && !cfg_write) begin
				if (cfg_offset == `OFF_IDENTITY) begin
					cfg_rdata <= identity_word; // R01
				end else if (is_csr(cfg_offset)) begin
					cfg_rdata <= csr_word; // R20
				end else begin
					cfg_rdata <= 32'h00000000;
				end
			end
		end
	end
endmodule

// ---- hw/cfg_id_csr_regs.vh ----
// Offsets, bit positions and reset values of the identity and command/status words
`ifndef CFG_ID_CSR_REGS_VH
`define CFG_ID_CSR_REGS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFF_IDENTITY 12'h000
`define OFF_CMD_STATUS 12'h004

// ----------------------------------------
// Identity (arbitrary values)
// ----------------------------------------
`define VENDOR_ID_RST 16'h5a5a
`define DEVICE_ID_RST 16'h0000

// ----------------------------------------
// Command/status bit positions
// ----------------------------------------
`define B_IOS 0
`define B_MS 1
`define B_BM 2
`define B_SC 3
`define B_MWI 4
`define B_PAL 5
`define B_PARITY_RESPONSE_ENABLE 6
`define B_WAIT 7
`define B_SYSTEM_ERROR_ENABLE 8
`define B_MFBB 9
`define B_TFBB 23
`define B_DPD 24
`define B_SEL_LO 25
`define B_SEL_HI 26
`define B_STA 27
`define B_RTA 28
`define B_RMA 29
`define B_SSERR 30
`define B_DPE 31

// ----------------------------------------
// Constant fields and strap pattern
// ----------------------------------------
`define SEL_TIMING_MEDIUM 2'h1
`define TGT_STRAP_PATTERN 2'h2

`endif

// ---- hw/w1c_flag.v ----
// One sticky error flag, set by hardware, cleared by writing one
`timescale 1ns/1ps
module w1c_flag (
	mclk,
	rst_n,
	set_pulse,
	clr_pulse,
	flag_q
);
	input wire mclk;
	input wire rst_n;
	input wire set_pulse;
	input wire clr_pulse;
	output reg flag_q;

	// Set wins over a clear in the same cycle
	always @(posedge mclk) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else if (set_pulse) begin
			flag_q <= 1'b1;
		end else if (clr_pulse) begin
			flag_q <= 1'b0;
		end
	end
endmodule

// ---- verification/cfg_id_csr_bench.sv ----
// Self-checking bench for the identity and command/status block
`timescale 1ns/1ps
module cfg_id_csr_bench;
	reg mclk = 0, rst_n = 0, pwr_rst_n = 0, req = 0, wr = 0, fire = 0;
	reg [2:0] strap = 3'h6, sel = 0;
	reg [11:0] off = 0;
	reg [3:0] be = 0;
	reg [31:0] wd = 0, exp_q = 0, got, m, seed = 32'h31ae;
	wire [31:0] rdata;
	wire [7:0] ev;
	wire ack, serr, refuse, perr_ok, bm, mem_en, io_en, vme_ok, fifo_ok, fbb;
	integer err_total = 0, n_tests = 0, i, k;
	always #25 mclk = ~mclk;
	evt_src src (.mclk(mclk), .fire(fire), .sel(sel), .ev(ev));
	cfg_id_csr uut (.mclk(mclk), .rst_n(rst_n), .pwr_rst_n(pwr_rst_n),
		.vme_addr_strap(strap), .cfg_req(req), .cfg_write(wr), .cfg_offset(off),
		.cfg_byte_en(be), .cfg_wdata(wd), .cfg_rdata(rdata), .cfg_ack(ack),
		.mst_data_parity_err(ev[0]), .tgt_addr_parity_err(ev[1]), .tgt_data_parity_err(ev[2]),
		.mst_perr_driven(ev[3]), .tgt_perr_seen(ev[4]), .mst_master_abort(ev[5]),
		.mst_target_abort(ev[6]), .tgt_target_abort(ev[7]), .serr_drive(serr),
		.perr_drive_allow(perr_ok), .addr_parity_refuse(refuse), .bus_master_enable(bm),
		.target_memory_enable(mem_en), .target_io_enable(io_en), .vme_slave_accept(vme_ok),
		.fifo_accept_enable(fifo_ok), .fast_back_to_back_allow(fbb));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task final_report;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, err_total);
			if (err_total == 0 && n_tests > 0) begin
				$display("All tests passed");
			end else begin
				$display("Some tests failed");
			end
			$finish;
		end
	endtask
	task cmp(input [31:0] g, input [31:0] e);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("[FAIL] %0t got %h expected %h", $time, g, e);
			end
		end
	endtask
	task acc(input w, input [11:0] o, input [3:0] b, input [31:0] d);
		begin
			@(posedge mclk);
			req <= 1;
			wr <= w;
			off <= o;
			be <= b;
			wd <= d;
			@(posedge mclk);
			req <= 0;
			#1;
			if (ack !== 1'b1) begin
				err_total = err_total + 1;
				$display("[FAIL] %0t no answer", $time);
				final_report;
			end
			got = rdata;
		end
	endtask
	task wr_csr(input [3:0] b, input [31:0] d);
		begin
			acc(1, 12'h004, b, d);
			for (k = 0; k < 4; k = k + 1) begin
				m[8 * k +: 8] = b[k] ? 8'hff : 8'h00;
			end
			exp_q = (exp_q & ~(m & 32'h147) | (d & m & 32'h147)) & ~(d & m & 32'hf9000000);
		end
	endtask
	task chk_csr;
		begin
			acc(0, 12'h004, 4'hf, 0);
			cmp(got, exp_q);
			cmp({29'h0, bm, mem_en, io_en}, {29'h0, exp_q[2:0]});
			cmp({28'h0, perr_ok, vme_ok, fifo_ok, fbb}, {28'h0, exp_q[6], exp_q[2], exp_q[2], 1'b0});
		end
	endtask
	task fire_ev(input [2:0] s);
		begin
			@(posedge mclk);
			fire <= 1;
			sel <= s;
			@(posedge mclk);
			fire <= 0;
			#1;
			cmp({31'h0, serr}, {31'h0, s == 1 && exp_q[6] && exp_q[8]});
			cmp({31'h0, refuse}, {31'h0, s == 1 && exp_q[6] && exp_q[8]});
			@(posedge mclk);
			case (s)
			0, 2: exp_q[31] = 1;
			1: exp_q[31:30] = {1'b1, exp_q[30] | (exp_q[6] & exp_q[8])};
			3, 4: exp_q[24] = exp_q[24] | exp_q[6];
			5: exp_q[29] = 1;
			6: exp_q[28] = 1;
			default: exp_q[27] = 1;
			endcase
		end
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1;
		pwr_rst_n <= 1;
		@(posedge mclk);
		exp_q = 32'h02000007;
		acc(0, 12'h000, 4'hf, 0);
		cmp(got, 32'h00005a5a);
		acc(1, 12'h000, 4'hf, $random(seed));
		acc(0, 12'h000, 4'hf, 0);
		cmp(got, 32'h00005a5a);
		acc(0, 12'h008, 4'hf, 0);
		cmp(got, 0);
		chk_csr;
		for (i = 0; i < 16; i = i + 1) begin
			if (i == 8) wr_csr(4'h3, 32'h00000147);
			fire_ev(i[2:0]);
			chk_csr;
			wr_csr(4'h8, 32'h0);
			chk_csr;
			wr_csr(4'h8, 32'hff000000);
			chk_csr;
		end
		repeat (8) begin
			wr_csr($random(seed), $random(seed) & 32'hf9000147);
			chk_csr;
		end
		@(posedge mclk);
		strap <= 3'h0;
		rst_n <= 0;
		repeat (4) @(posedge mclk);
		rst_n <= 1;
		@(posedge mclk);
		exp_q = 32'h02000000;
		chk_csr;
		final_report;
	end
endmodule
bind cfg_id_csr cfg_id_csr_chk chk (.mclk(mclk), .rst_n(rst_n), .pwr_rst_n(pwr_rst_n),
	.cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_offset(cfg_offset),
	.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .tgt_addr_parity_err(tgt_addr_parity_err),
	.mst_master_abort(mst_master_abort), .serr_drive(serr_drive),
	.perr_drive_allow(perr_drive_allow), .addr_parity_refuse(addr_parity_refuse),
	.bus_master_enable(bus_master_enable), .vme_slave_accept(vme_slave_accept),
	.fifo_accept_enable(fifo_accept_enable), .fast_back_to_back_allow(fast_back_to_back_allow));

// ---- verification/cfg_id_csr_chk.sv ----
// Assertion checker for the identity and command/status block
`timescale 1ns/1ps
module cfg_id_csr_chk (
	input wire mclk,
	input wire rst_n,
	input wire pwr_rst_n,
	input wire cfg_req,
	input wire cfg_write,
	input wire [11:0] cfg_offset,
	input wire [31:0] cfg_rdata,
	input wire cfg_ack,
	input wire tgt_addr_parity_err,
	input wire mst_master_abort,
	input wire serr_drive,
	input wire perr_drive_allow,
	input wire addr_parity_refuse,
	input wire bus_master_enable,
	input wire vme_slave_accept,
	input wire fifo_accept_enable,
	input wire fast_back_to_back_allow
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n || !pwr_rst_n);
	sequence rd_at(logic [11:0] o);
		cfg_req && !cfg_write && cfg_offset == o;
	endsequence
	AST_ACK: assert property (cfg_req |=> cfg_ack) else $error("no ack");
	AST_NO_ACK: assert property (!cfg_req |=> !cfg_ack) else $error("stray ack");
	AST_ID: assert property (rd_at(12'h000) |=> cfg_rdata == 32'h00005a5a)
		else $error("identity word wrong");
	AST_CONST: assert property (rd_at(12'h004) |=> cfg_rdata[26:25] == 2'b01
		&& cfg_rdata[23:9] == 0 && !cfg_rdata[7] && cfg_rdata[5:3] == 0) else $error("fixed bits");
	AST_ENABLES: assert property (rd_at(12'h004) |=> cfg_rdata[6] == $past(perr_drive_allow)
		&& cfg_rdata[2] == $past(bus_master_enable)) else $error("enable bits");
	AST_UNMAPPED: assert property (cfg_req && !cfg_write && cfg_offset != 0
		&& cfg_offset != 4 |=> cfg_rdata == 0) else $error("unmapped read");
	sequence abort_then_idle;
		mst_master_abort ##1 !cfg_req;
	endsequence
	AST_RMA: assert property (abort_then_idle ##1 rd_at(12'h004) |=> cfg_rdata[29])
		else $error("abort flag");
	AST_SERR: assert property (serr_drive |-> tgt_addr_parity_err && perr_drive_allow)
		else $error("system error gate");
	AST_REFUSE: assert property (addr_parity_refuse == serr_drive) else $error("refuse");
	AST_FBB: assert property (!fast_back_to_back_allow) else $error("fast b2b");
	AST_VME: assert property (vme_slave_accept == bus_master_enable
		&& fifo_accept_enable == bus_master_enable) else $error("slave gate");
endmodule

// ---- verification/evt_src.sv ----
// Far-side agent model: one-cycle event pulses
`timescale 1ns/1ps
module evt_src (
	input wire mclk,
	input wire fire,
	input wire [2:0] sel,
	output reg [7:0] ev
);
	initial ev = 8'h00;
	always @(posedge mclk) begin
		ev <= fire ? (8'h01 << sel) : 8'h00;
	end
endmodule
